/* design/ssc_defs.svh */
// register offsets, bit positions and reset values of the status/control block
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_AW        3
`define SSC_DW        8
`define SSC_A_FMT     3'h0
`define SSC_A_TRC     3'h1
`define SSC_A_NEC     3'h2
`define SSC_A_ST1     3'h3
`define SSC_A_ST2     3'h4
`define SSC_A_DAT     3'h5
`define SSC_F_LOOP    7
`define SSC_F_PORT    6
`define SSC_F_POL     5
`define SSC_F_NINE    4
`define SSC_F_ROUSE   3
`define SSC_F_ILTY    2
`define SSC_F_PEN     1
`define SSC_F_PTY     0
`define SSC_C_TBIE    7
`define SSC_C_TDIE    6
`define SSC_C_RFIE    5
`define SSC_C_LQIE    4
`define SSC_C_TXON    3
`define SSC_C_RXON    2
`define SSC_C_SLEEP   1
`define SSC_C_BRK     0
`define SSC_N_RX9     7
`define SSC_N_TX9     6
`define SSC_N_DMAR    5
`define SSC_N_DMAT    4
`define SSC_S_TBE     7
`define SSC_S_TDN     6
`define SSC_S_RXF     5
`define SSC_S_LQ      4
`define SSC_S_OVR     3
`define SSC_S_NOI     2
`define SSC_S_FRM     1
`define SSC_S_PAR     0
`define SSC_S2_BRK    1
`define SSC_S2_ACT    0
`define SSC_ERR_MASK  8'h0f
`define SSC_RDCLR_MSK 8'h3f
`define SSC_RW_NEC    8'h7f
`define SSC_ST1_RST   8'hc0
`define SSC_ZERO8     8'h00
`endif

/* design/ssc_pkg.sv */
// types shared by the status/control block and its neighbours
`default_nettype none
package ssc_pkg;
  typedef struct packed {
    logic       char_done;
    logic [8:0] data;
    logic       parity_bad;
    logic       noise;
    logic       stop_zero;
    logic       is_break;
    logic       idle_seen;
    logic       start_low;
    logic       false_start;
    logic       ones_seen;
  } ssc_rx_ev_t;
  typedef struct packed {
    logic load_req;
    logic busy;
    logic idle_ack;
    logic brk_ack;
  } ssc_tx_ev_t;
  typedef struct packed {
    logic       on;
    logic       brk_send;
    logic       brk_one;
    logic       idle_pend;
    logic       load;
    logic [8:0] data;
  } ssc_tx_ctl_t;
  typedef struct packed {
    logic       on;
    logic       sleep;
    logic [7:0] fmt;
  } ssc_rx_ctl_t;
  typedef struct packed {
    logic tx;
    logic rx;
    logic err;
  } ssc_irq_t;
  typedef struct packed {
    logic [7:0]  fmt;
    logic [7:0]  trc;
    logic [7:0]  nec;
    logic [7:0]  st1;
    logic [7:0]  st2;
    logic [7:0]  arm1;
    logic [7:0]  arm2;
    logic [7:0]  rx_buf;
    logic [7:0]  tx_buf;
    logic        quiet_armed;
    logic        brk_armed;
    logic        off_busy;
    ssc_tx_ctl_t txc;
    logic [7:0]  rd_data;
    ssc_irq_t    irq;
  } ssc_state_t;
endpackage
`default_nettype wire

/* design/ssc_core.sv */
// control, status flags and interrupt requests of the serial interface
`default_nettype none
`include "ssc_defs.svh"
// Functional notes
// - tx_on off then on during a send queues one idle character after it.
// - writes to tx_on and rx_on are ignored while port_on is low.
// - clearing rx_on stops receive, keeps receive flags; reset clears both enables.
// - rx_sleep suppresses receive irqs; chosen wake condition clears it.
// - brk_send set then cleared gives one break; held set gives continuous breaks.
// - brk_send toggled while an idle is queued keeps the idle queued and also queues one break.
// - rx_ninth takes bit 8 (9-bit) or bit 7 (8-bit); reset keeps it.
// - tx_ninth goes to shifter with data buffer; reset keeps it.
// - error irq when an error flag and its enable are both set.
// - tx_buf_empty sets on transfer, clears by status read then data write.
// - tx_done set while buffer empty and nothing sending; clears when queued.
// - rx_full sets on receive transfer; clears by status read then data read.
// - line_quiet sets on idle line, irq if enabled, cleared by read sequence.
// - line_quiet needs a character setting rx_full after enable or clear.
// - overrun keeps buffer, drops new char; cleared only if set at status read.
// - noise_flag sets on noise, clears by read sequence, reset clears it.
// - frame_err sets on zero stop bit, clears by read sequence.
// - parity_err sets on parity failure, clears by read sequence.
// - break sets break_seen, frame_err, rx_full; clears rx_ninth in 9-bit.
// - break_seen clears by status2 read then data read; rearms after ones.
// - rx_active sets on low first sample, clears on false start or idle.
// - port_on low forces tx_buf_empty and tx_done high, kills tx irq.
// - rouse_method 1 wakes on address mark, 0 on idle line.
module ssc_core
  import ssc_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // register port
  input  wire logic [`SSC_AW-1:0]  addr,
  input  wire logic [`SSC_DW-1:0]  wr_data,
  input  wire logic                wr_stb,
  input  wire logic                rd_stb,
  output logic      [`SSC_DW-1:0]  rd_data,
  // receiver engine
  input  wire ssc_rx_ev_t          rx_ev,
  output ssc_rx_ctl_t              rx_ctl,
  // transmitter engine
  input  wire ssc_tx_ev_t          tx_ev,
  output ssc_tx_ctl_t              tx_ctl,
  // interrupt requests
  output ssc_irq_t                 irq
);

  ssc_state_t st_reg;
  ssc_state_t st_next;

  logic wr_fmt;
  logic wr_trc;
  logic wr_nec;
  logic wr_dat;
  logic rd_st1;
  logic rd_st2;
  logic rd_dat;
  logic port_on;
  logic rx_live;
  logic tx_take;
  logic char_ok;
  logic char_ovr;
  logic brk_hit;
  logic wake_msb;

  assign wr_fmt   = wr_stb && (addr == `SSC_A_FMT);
  assign wr_trc   = wr_stb && (addr == `SSC_A_TRC);
  assign wr_nec   = wr_stb && (addr == `SSC_A_NEC);
  assign wr_dat   = wr_stb && (addr == `SSC_A_DAT);
  assign rd_st1   = rd_stb && (addr == `SSC_A_ST1);
  assign rd_st2   = rd_stb && (addr == `SSC_A_ST2);
  assign rd_dat   = rd_stb && (addr == `SSC_A_DAT);
  assign port_on  = st_reg.fmt[`SSC_F_PORT];
  // receive events count only while the receiver runs
  assign rx_live  = port_on && st_reg.trc[`SSC_C_RXON];
  assign tx_take  = tx_ev.load_req && !st_reg.st1[`SSC_S_TBE] && port_on
                    && st_reg.trc[`SSC_C_TXON];
  assign char_ovr = rx_live && rx_ev.char_done && st_reg.st1[`SSC_S_RXF];
  assign char_ok  = rx_live && rx_ev.char_done && !st_reg.st1[`SSC_S_RXF];
  assign brk_hit  = char_ok && rx_ev.is_break && st_reg.brk_armed;
  assign wake_msb = st_reg.fmt[`SSC_F_NINE] ? rx_ev.data[8] : rx_ev.data[7];

  always_comb
  begin
    st_next          = st_reg;
    st_next.txc.load = 1'b0;

    // configuration writes
    if (wr_fmt)
    begin
      st_next.fmt = wr_data;
    end
    if (wr_trc)
    begin
      st_next.trc[`SSC_C_TBIE] = wr_data[`SSC_C_TBIE];
      st_next.trc[`SSC_C_TDIE] = wr_data[`SSC_C_TDIE];
      st_next.trc[`SSC_C_RFIE] = wr_data[`SSC_C_RFIE];
      st_next.trc[`SSC_C_LQIE] = wr_data[`SSC_C_LQIE];
      st_next.trc[`SSC_C_SLEEP] = wr_data[`SSC_C_SLEEP];
      st_next.trc[`SSC_C_BRK]  = wr_data[`SSC_C_BRK];
      if (port_on)
      begin
        st_next.trc[`SSC_C_TXON] = wr_data[`SSC_C_TXON];
        st_next.trc[`SSC_C_RXON] = wr_data[`SSC_C_RXON];
      end
      // a fresh receiver enable must see a character before idle counts
      if (port_on && wr_data[`SSC_C_RXON] && !st_reg.trc[`SSC_C_RXON])
      begin
        st_next.quiet_armed = 1'b0;
      end
      // off-then-on while busy asks the sender for one idle character
      if (port_on && tx_ev.busy)
      begin
        if (st_reg.trc[`SSC_C_TXON] && !wr_data[`SSC_C_TXON])
        begin
          st_next.off_busy = 1'b1;
        end
        if (st_reg.off_busy && !st_reg.trc[`SSC_C_TXON] && wr_data[`SSC_C_TXON])
        begin
          st_next.txc.idle_pend = 1'b1;
          st_next.off_busy      = 1'b0;
        end
      end
      // a set-then-clear of break leaves one break for the sender to emit
      if (st_reg.trc[`SSC_C_BRK] && !wr_data[`SSC_C_BRK])
      begin
        st_next.txc.brk_one = 1'b1;
      end
    end
    if (!tx_ev.busy)
    begin
      st_next.off_busy = 1'b0;
    end
    if (tx_ev.idle_ack)
    begin
      st_next.txc.idle_pend = 1'b0;
    end
    if (tx_ev.brk_ack)
    begin
      st_next.txc.brk_one = 1'b0;
    end
    // dma bits are storage here, except tx dma, which masks the buffer-empty tx irq; software keeps them at zero
    if (wr_nec)
    begin
      st_next.nec = (wr_data & `SSC_RW_NEC) | (st_reg.nec & ~`SSC_RW_NEC);
    end

    // status read snapshots decide what the following data access clears
    if (rd_st1)
    begin
      st_next.arm1 = st_reg.st1;
    end
    if (rd_st2)
    begin
      st_next.arm2 = st_reg.st2;
    end
    if (rd_dat)
    begin
      // only flags seen set at the status read are cleared
      st_next.st1  = st_reg.st1 & ~(st_reg.arm1 & `SSC_RDCLR_MSK);
      st_next.arm1 = st_reg.arm1 & ~`SSC_RDCLR_MSK;
      if (st_reg.arm2[`SSC_S2_BRK])
      begin
        st_next.st2[`SSC_S2_BRK]  = 1'b0;
        st_next.arm2[`SSC_S2_BRK] = 1'b0;
      end
      if (st_reg.arm1[`SSC_S_LQ])
      begin
        st_next.quiet_armed = 1'b0;
      end
    end
    if (wr_dat)
    begin
      st_next.tx_buf = wr_data;
      if (st_reg.arm1[`SSC_S_TBE])
      begin
        st_next.st1[`SSC_S_TBE]  = 1'b0;
        st_next.arm1[`SSC_S_TBE] = 1'b0;
      end
    end

    // buffer to shifter transfer; set after clears so a same-cycle set wins
    if (tx_take)
    begin
      st_next.txc.load        = 1'b1;
      st_next.txc.data        = {st_reg.nec[`SSC_N_TX9], st_reg.tx_buf};
      st_next.st1[`SSC_S_TBE] = 1'b1;
    end

    // receive events
    if (char_ovr)
    begin
      st_next.st1[`SSC_S_OVR] = 1'b1;
    end
    if (char_ok)
    begin
      st_next.rx_buf           = rx_ev.data[7:0];
      st_next.nec[`SSC_N_RX9]  = wake_msb;
      st_next.st1[`SSC_S_RXF]  = 1'b1;
      st_next.quiet_armed      = 1'b1;
      if (rx_ev.parity_bad)
      begin
        st_next.st1[`SSC_S_PAR] = 1'b1;
      end
      if (rx_ev.noise)
      begin
        st_next.st1[`SSC_S_NOI] = 1'b1;
      end
      if (rx_ev.stop_zero)
      begin
        st_next.st1[`SSC_S_FRM] = 1'b1;
      end
    end
    if (brk_hit)
    begin
      st_next.st2[`SSC_S2_BRK] = 1'b1;
      st_next.st1[`SSC_S_FRM]  = 1'b1;
      st_next.brk_armed        = 1'b0;
      if (st_reg.fmt[`SSC_F_NINE])
      begin
        st_next.nec[`SSC_N_RX9] = 1'b0;
      end
    end
    if (rx_live && rx_ev.ones_seen)
    begin
      st_next.brk_armed = 1'b1;
    end
    if (rx_live && rx_ev.idle_seen && st_reg.quiet_armed)
    begin
      st_next.st1[`SSC_S_LQ] = 1'b1;
    end
    if (rx_live && (rx_ev.false_start || rx_ev.idle_seen))
    begin
      st_next.st2[`SSC_S2_ACT] = 1'b0;
    end
    if (rx_live && rx_ev.start_low)
    begin
      st_next.st2[`SSC_S2_ACT] = 1'b1;
    end
    // standby ends on the selected wake condition
    if (st_reg.trc[`SSC_C_SLEEP] && rx_live)
    begin
      if (st_reg.fmt[`SSC_F_ROUSE] && char_ok && wake_msb)
      begin
        st_next.trc[`SSC_C_SLEEP] = 1'b0;
      end
      if (!st_reg.fmt[`SSC_F_ROUSE] && rx_ev.idle_seen)
      begin
        st_next.trc[`SSC_C_SLEEP] = 1'b0;
      end
    end

    // transmitter flags pinned while the port is off
    if (!st_next.fmt[`SSC_F_PORT])
    begin
      st_next.st1[`SSC_S_TBE] = 1'b1;
    end
    st_next.st1[`SSC_S_TDN] = !st_next.fmt[`SSC_F_PORT]
                              || (st_next.st1[`SSC_S_TBE] && !tx_ev.busy
                                  && !st_next.txc.idle_pend && !st_next.txc.brk_one
                                  && !st_next.txc.load && !st_reg.txc.load
                                  && !st_next.trc[`SSC_C_BRK]);
    st_next.txc.on       = st_next.trc[`SSC_C_TXON];
    st_next.txc.brk_send = st_next.trc[`SSC_C_BRK];

    // read data, presented the cycle after the strobe
    st_next.rd_data = `SSC_ZERO8;
    if (rd_stb)
    begin
      case (addr)
        `SSC_A_FMT: st_next.rd_data = st_reg.fmt;
        `SSC_A_TRC: st_next.rd_data = st_reg.trc;
        `SSC_A_NEC: st_next.rd_data = st_reg.nec;
        `SSC_A_ST1: st_next.rd_data = st_reg.st1;
        `SSC_A_ST2: st_next.rd_data = st_reg.st2;
        `SSC_A_DAT: st_next.rd_data = st_reg.rx_buf;
        default:    st_next.rd_data = `SSC_ZERO8;
      endcase
    end

    // interrupt requests from the next flag values so they leave a flop
    st_next.irq.tx = st_next.fmt[`SSC_F_PORT]
                     && ((st_next.st1[`SSC_S_TBE] && st_next.trc[`SSC_C_TBIE]
                          && !st_next.nec[`SSC_N_DMAT])
                         || (st_next.st1[`SSC_S_TDN] && st_next.trc[`SSC_C_TDIE]));
    st_next.irq.rx = !st_next.trc[`SSC_C_SLEEP]
                     && ((st_next.st1[`SSC_S_RXF] && st_next.trc[`SSC_C_RFIE])
                         || (st_next.st1[`SSC_S_LQ] && st_next.trc[`SSC_C_LQIE]));
    st_next.irq.err = |(st_next.st1 & st_next.nec & `SSC_ERR_MASK);

    // synchronous reset; ninth bits and data buffers keep their contents
    if (sys_rst)
    begin
      st_next.fmt         = `SSC_ZERO8;
      st_next.trc         = `SSC_ZERO8;
      st_next.nec         = st_reg.nec & ~`SSC_RDCLR_MSK;
      st_next.st1         = `SSC_ST1_RST;
      st_next.st2         = `SSC_ZERO8;
      st_next.arm1        = `SSC_ZERO8;
      st_next.arm2        = `SSC_ZERO8;
      st_next.quiet_armed = 1'b0;
      st_next.brk_armed   = 1'b1;
      st_next.off_busy    = 1'b0;
      st_next.txc         = '0;
      st_next.txc.data    = st_reg.txc.data;
      st_next.rd_data     = `SSC_ZERO8;
      st_next.irq         = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  assign rd_data       = st_reg.rd_data;
  assign tx_ctl        = st_reg.txc;
  assign irq           = st_reg.irq;
  assign rx_ctl.on     = st_reg.trc[`SSC_C_RXON];
  assign rx_ctl.sleep  = st_reg.trc[`SSC_C_SLEEP];
  assign rx_ctl.fmt    = st_reg.fmt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_st1_rd_tbe;
    rd_st1 && st_reg.st1[`SSC_S_TBE];
  endsequence
  sequence s_dat_wr_quiet;
    wr_dat && port_on && st_reg.st1[`SSC_S_TBE] && st_reg.arm1[`SSC_S_TBE];
  endsequence

  chk_enable_lock: assert property (wr_trc && !port_on |=>
    st_reg.trc[`SSC_C_TXON] == $past(st_reg.trc[`SSC_C_TXON])
    && st_reg.trc[`SSC_C_RXON] == $past(st_reg.trc[`SSC_C_RXON]))
    else $error("enable bit changed while port off");
  chk_rx_flags_hold: assert property (!rx_live && !rd_stb |=>
    st_reg.st1[5:0] == $past(st_reg.st1[5:0]))
    else $error("receive flags moved while receiver off");
  chk_idle_wake: assert property (rx_live && st_reg.trc[`SSC_C_SLEEP]
    && !st_reg.fmt[`SSC_F_ROUSE] && rx_ev.idle_seen && !wr_trc |=> !rx_ctl.sleep)
    else $error("idle wake did not clear standby");
  chk_ninth_take: assert property (char_ok && !brk_hit && st_reg.fmt[`SSC_F_NINE]
    && !wr_nec |=> st_reg.nec[`SSC_N_RX9] == $past(rx_ev.data[8]))
    else $error("ninth bit not captured");
  chk_err_request: assert property (irq.err ==
    |(st_reg.st1 & st_reg.nec & `SSC_ERR_MASK))
    else $error("error request mismatch");
  chk_tbe_clear: assert property (s_st1_rd_tbe ##[1:4] s_dat_wr_quiet |=>
    !st_reg.st1[`SSC_S_TBE])
    else $error("empty flag not cleared by read then write");
  chk_done_empty: assert property (st_reg.st1[`SSC_S_TDN] |-> st_reg.st1[`SSC_S_TBE])
    else $error("done without empty buffer");
  chk_overrun_keep: assert property (char_ovr && !rd_stb |=>
    st_reg.st1[`SSC_S_OVR] && $stable(st_reg.rx_buf))
    else $error("overrun handling wrong");
  chk_quiet_guard: assert property ($rose(st_reg.st1[`SSC_S_LQ]) |->
    $past(st_reg.quiet_armed))
    else $error("idle flag set without prior character");
  chk_port_off: assert property (!port_on && !wr_fmt |=>
    st_reg.st1[`SSC_S_TBE] && st_reg.st1[`SSC_S_TDN] && !irq.tx)
    else $error("port off did not pin transmitter flags");
  chk_break_set: assert property (brk_hit |=> st_reg.st2[`SSC_S2_BRK]
    && st_reg.st1[`SSC_S_FRM] && st_reg.st1[`SSC_S_RXF])
    else $error("break flags not set together");

endmodule
`default_nettype wire

/* tb/ssc_tx_model.sv */
// transmit engine stand-in: runs one data, idle or break job at a time
`default_nettype none
module ssc_tx_model
  import ssc_pkg::*;
#(
  parameter int DUR = 20
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // engine side of the block
  input  wire ssc_tx_ctl_t tx_ctl,
  output var  ssc_tx_ev_t  tx_ev
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic [1:0] kind;
  logic       ack_i;
  logic       ack_b;
  // busy covers data, idle and break alike; shifter asks only when free
  assign tx_ev = '{load_req: tx_ctl.on && (cnt == 8'h00), busy: (cnt != 8'h00),
                   idle_ack: ack_i, brk_ack: ack_b};
  // no new job in the ack cycle: the owed flag only drops at that edge
  always_ff @(posedge clk)
  begin
    ack_i <= 1'b0;
    ack_b <= 1'b0;
    if (sys_rst)
    begin
      cnt  <= 8'h00;
      kind <= 2'h0;
    end
    else if (cnt != 8'h00)
    begin
      cnt   <= cnt - 8'h01;
      ack_i <= (cnt == 8'h01) && (kind == 2'h2);
      ack_b <= (cnt == 8'h01) && (kind == 2'h3);
    end
    else if (!(ack_i || ack_b))
    begin
      kind <= tx_ctl.load ? 2'h1 : (tx_ctl.idle_pend ? 2'h2 : 2'h3);
      if (tx_ctl.load || tx_ctl.idle_pend || tx_ctl.brk_one || tx_ctl.brk_send)
        cnt <= DUR[7:0];
    end
  end
endmodule
`default_nettype wire

/* tb/sci_status_control_logic_tb.sv */
// self-checking bench of the serial status and control block
`default_nettype none
`include "ssc_defs.svh"
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); \
      miscompares++; \
    end \
  end
module sci_status_control_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  localparam logic [2:0] FMT = `SSC_A_FMT;
  localparam logic [2:0] TRC = `SSC_A_TRC;
  localparam logic [2:0] NEC = `SSC_A_NEC;
  localparam logic [2:0] ST1 = `SSC_A_ST1;
  localparam logic [2:0] ST2 = `SSC_A_ST2;
  localparam logic [2:0] DAT = `SSC_A_DAT;
  logic        clk;
  logic        sys_rst;
  logic [2:0]  addr;
  logic [7:0]  wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rd_data;
  ssc_rx_ev_t  rx_ev;
  ssc_rx_ctl_t rx_ctl;
  ssc_tx_ev_t  tx_ev;
  ssc_tx_ctl_t tx_ctl;
  ssc_irq_t    irq;
  int          miscompares;
  int          compares;

  ssc_core DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rx_ev(rx_ev),
    .rx_ctl(rx_ctl), .tx_ev(tx_ev), .tx_ctl(tx_ctl), .irq(irq));
  ssc_tx_model #(.DUR(20)) u_model (.clk(clk), .sys_rst(sys_rst), .tx_ctl(tx_ctl),
    .tx_ev(tx_ev));

  always #4 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr    <= a;
    wr_data <= v;
    wr_stb  <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    v = rd_data;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v & m, e)
  endtask
  task automatic clr;
    logic [7:0] v;
    rd(ST1, v);
    rd(DAT, v);
  endtask
  task automatic ev(input ssc_rx_ev_t e);
    @(posedge clk);
    rx_ev <= e;
    @(posedge clk);
    rx_ev <= '0;
  endtask
  // q: parity, noise, stop zero, break
  task automatic chr(input logic [8:0] v, input logic [3:0] q);
    ssc_rx_ev_t e;
    e = '0;
    e.char_done = 1'b1;
    e.data = v;
    {e.parity_bad, e.noise, e.stop_zero, e.is_break} = q;
    ev(e);
  endtask
  // k: idle, start low, false start, ones
  task automatic sig(input logic [3:0] k);
    ssc_rx_ev_t e;
    e = '0;
    {e.idle_seen, e.start_low, e.false_start, e.ones_seen} = k;
    ev(e);
  endtask

  task automatic t_reset;
    rdchk(ST1, 8'hff, 8'hc0);
    rdchk(ST2, 8'hff, 8'h00);
    rdchk(TRC, 8'hff, 8'h00);
    rdchk(NEC, 8'h0f, 8'h00);
    rdchk(3'h7, 8'hff, 8'h00);
    `CHK(irq, 3'h0)
  endtask
  task automatic t_enable;
    wr(TRC, 8'h3c);
    rdchk(TRC, 8'hff, 8'h30);
    wr(FMT, 8'h40);
    wr(TRC, 8'h0c);
    rdchk(TRC, 8'hff, 8'h0c);
    `CHK(rx_ctl.on, 1'b1)
  endtask
  task automatic t_rx;
    wr(TRC, 8'h24);
    chr(9'h05a, 4'h0);
    cyc(1);
    `CHK(irq.rx, 1'b1)
    rdchk(ST1, 8'h3f, 8'h20);
    chr(9'h033, 4'h0);
    rdchk(DAT, 8'hff, 8'h5a);
    rdchk(ST1, 8'h3f, 8'h08);
    wr(TRC, 8'h20);
    chr(9'h0aa, 4'h0);
    rdchk(ST1, 8'h3f, 8'h08);
    rdchk(DAT, 8'hff, 8'h5a);
    rdchk(ST1, 8'h3f, 8'h00);
    `CHK(irq.rx, 1'b0)
    wr(TRC, 8'h04);
  endtask
  task automatic t_err;
    chr(9'h011, 4'he);
    rdchk(ST1, 8'h0f, 8'h07);
    for (int i = 0; i < 4; i++)
    begin
      wr(NEC, 8'h01 << i);
      cyc(1);
      `CHK(irq.err, (i < 3))
      rdchk(NEC, 8'h3f, 8'h01 << i);
    end
    clr();
    rdchk(ST1, 8'h0f, 8'h00);
    wr(NEC, 8'h0f);
    cyc(1);
    `CHK(irq.err, 1'b0)
  endtask
  task automatic t_ninth;
    logic [7:0] fm [3] = '{8'h50, 8'h40, 8'h40};
    logic [8:0] dv [3] = '{9'h100, 9'h080, 9'h07f};
    logic [7:0] ex [3] = '{8'h80, 8'h80, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      wr(FMT, fm[i]);
      chr(dv[i], 4'h0);
      rdchk(NEC, 8'h80, ex[i]);
      clr();
    end
  endtask
  task automatic t_break;
    logic [7:0] v;
    wr(FMT, 8'h50);
    chr(9'h100, 4'h3);
    rdchk(ST2, 8'h02, 8'h02);
    rdchk(ST1, 8'h22, 8'h22);
    rdchk(NEC, 8'h80, 8'h00);
    rd(DAT, v);
    rdchk(ST2, 8'h02, 8'h00);
    chr(9'h100, 4'h3);
    rdchk(ST2, 8'h02, 8'h00);
    clr();
    sig(4'h1);
    chr(9'h100, 4'h3);
    rdchk(ST2, 8'h02, 8'h02);
    clr();
  endtask
  task automatic t_quiet;
    wr(FMT, 8'h40);
    wr(TRC, 8'h10);
    wr(TRC, 8'h14);
    sig(4'h8);
    rdchk(ST1, 8'h10, 8'h00);
    chr(9'h001, 4'h0);
    sig(4'h8);
    rdchk(ST1, 8'h30, 8'h30);
    `CHK(irq.rx, 1'b1)
    clr();
    rdchk(ST1, 8'h30, 8'h00);
    sig(4'h8);
    rdchk(ST1, 8'h10, 8'h00);
  endtask
  task automatic t_active;
    sig(4'h4);
    rdchk(ST2, 8'h01, 8'h01);
    sig(4'h2);
    rdchk(ST2, 8'h01, 8'h00);
    sig(4'h4);
    sig(4'h8);
    rdchk(ST2, 8'h01, 8'h00);
  endtask
  task automatic t_sleep;
    wr(TRC, 8'h26);
    chr(9'h000, 4'h0);
    cyc(1);
    `CHK(irq.rx, 1'b0)
    sig(4'h8);
    rdchk(TRC, 8'h02, 8'h00);
    clr();
    wr(FMT, 8'h58);
    wr(TRC, 8'h06);
    chr(9'h000, 4'h0);
    rdchk(TRC, 8'h02, 8'h02);
    `CHK(rx_ctl.sleep, 1'b1)
    `CHK(rx_ctl.fmt, 8'h58)
    clr();
    chr(9'h1ff, 4'h0);
    rdchk(TRC, 8'h02, 8'h00);
    clr();
  endtask
  task automatic t_tx;
    logic [7:0] v;
    int         n;
    wr(FMT, 8'h50);
    wr(NEC, 8'h40);
    wr(TRC, 8'h48);
    rd(ST1, v);
    wr(DAT, 8'ha5);
    n = 0;
    while (tx_ctl.load !== 1'b1 && n < 50)
    begin
      cyc(1);
      n++;
    end
    `CHK(tx_ctl.data, 9'h1a5)
    rdchk(ST1, 8'hc0, 8'h80);
    wr(TRC, 8'h40);
    wr(TRC, 8'h48);
    cyc(1);
    `CHK(tx_ctl.idle_pend, 1'b1)
    `CHK(tx_ctl.on, 1'b1)
    cyc(60);
    rdchk(ST1, 8'hc0, 8'hc0);
    `CHK(irq.tx, 1'b1)
    wr(TRC, 8'h49);
    cyc(1);
    `CHK(tx_ctl.brk_send, 1'b1)
    wr(TRC, 8'h48);
    cyc(1);
    `CHK(tx_ctl.brk_one, 1'b1)
    rdchk(ST1, 8'h40, 8'h00);
    wr(FMT, 8'h10);
    rdchk(ST1, 8'hc0, 8'hc0);
    `CHK(irq.tx, 1'b0)
  endtask

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    rx_ev = '0;
    miscompares = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_enable();
    t_rx();
    t_err();
    t_ninth();
    t_break();
    t_quiet();
    t_active();
    t_sleep();
    t_tx();
    tally_and_finish();
  end
  // whole run needs about 310 cycles; this allows about 40 times that
  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
